// [pqf_pkg.sv]
// pqf_pkg: constants, frame codes and state encoding for the port sequencer
// assumes a 32-slot command list and a 32-bit data path from the link
package pqf_pkg;
	localparam int SLOTS      = 32;
	localparam int SLOT_W     = 5;
	localparam int DATA_W     = 32;
	localparam int FIFO_DEPTH = 8;
	// received frame kinds, as decoded by the link layer
	localparam logic [2:0] FRM_REG   = 3'h1;
	localparam logic [2:0] FRM_PIOS  = 3'h2;
	localparam logic [2:0] FRM_DATA  = 3'h3;
	localparam logic [2:0] FRM_DMAS  = 3'h4;
	localparam logic [2:0] FRM_SDB   = 3'h5;
	localparam logic [SLOTS-1:0] BITS_ZERO = 32'h0000_0000;
	localparam logic [SLOTS-1:0] BIT_ONE   = 32'h0000_0001;
	// power request codes toward the link
	localparam logic [1:0] PWR_PARTIAL = 2'h1;
	localparam logic [1:0] PWR_SLUMBER = 2'h2;
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_FETCH    = 4'b0001,
		ST_XMIT     = 4'b0010,
		ST_PF_PKT   = 4'b0011,
		ST_PF_DESC  = 4'b0100,
		ST_PIO_ENT  = 4'b0101,
		ST_PKT_ENT  = 4'b0110,
		ST_PIO_UPD  = 4'b0111,
		ST_PIO_RX   = 4'b1000,
		ST_D2H_INT  = 4'b1001,
		ST_D2H_QUIET= 4'b1010,
		ST_DMA_SET  = 4'b1011,
		ST_SDB      = 4'b1100,
		ST_PWR      = 4'b1101
	} pqf_state_e;
endpackage

// [pqf_fifo.sv]
// pqf_fifo: flip-flop fifo with valid/ready on both sides
// assumes one clock; depth is a power of two
`timescale 1ns/100ps
module pqf_fifo
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
)
(
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_nrst,
	// fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// drain side
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_r;
	logic [AW-1:0]    rd_r;
	logic [AW:0]      cnt_r;
	wire              push = i_in_valid && o_in_ready;
	wire              pop  = o_out_valid && i_out_ready;

	// honest flags straight from the count
	assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_r != '0);
	assign o_out_data  = mem_r[rd_r];

	////////////////////////////////////////////////////////////////////////
	// storage is written without reset, pointers and count are reset
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_r[wr_r] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + AW'(1);
			if (pop)
				rd_r <= rd_r + AW'(1);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [pqf_seq.sv]
// pqf_seq: port command sequencer for pio reads and native queued commands
// assumes a link layer that decodes received frames into one-cycle pulses
// and a memory engine that acknowledges each fetch/prefetch/transfer step
`timescale 1ns/100ps
module pqf_seq
	import pqf_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_nrst,
	// software command control
	input  wire logic [SLOTS-1:0]  i_issue_set,
	input  wire logic [SLOTS-1:0]  i_active_set,
	input  wire logic              i_hdr_prefetch,
	input  wire logic              i_hdr_packet,
	input  wire logic              i_hdr_queued,
	input  wire logic              i_aggr_pm_en,
	input  wire logic              i_slumber_sel,
	// memory engine step handshake
	input  wire logic              i_step_done,
	// link: transmit result and received frames
	input  wire logic              i_tx_ok,
	input  wire logic              i_rx_busy,
	input  wire logic              i_frm_valid,
	input  wire logic [2:0]        i_frm_kind,
	input  wire logic              i_frm_intr,
	input  wire logic [SLOTS-1:0]  i_frm_sdb_bits,
	// link received data
	input  wire logic              i_rx_valid,
	input  wire logic [DATA_W-1:0] i_rx_data,
	output logic                   o_rx_ready,
	// memory write data
	output logic                   o_mem_valid,
	output logic      [DATA_W-1:0] o_mem_data,
	input  wire logic              i_mem_ready,
	// status
	output logic [SLOTS-1:0]       o_command_issue_bits,
	output logic [SLOTS-1:0]       o_queued_active_bits,
	output logic [SLOT_W-1:0]      o_slot,
	output logic [3:0]             o_state,
	output logic                   o_intr,
	output logic                   o_pwr_req,
	output logic [1:0]             o_pwr_mode
);
	pqf_state_e         st_r, st_nxt;
	logic [SLOTS-1:0]   ci_r, sact_r;
	logic [SLOT_W-1:0]  slot_r;
	logic               pkt_r, pf_r, q_r, pkt_sent_r;
	logic               intr_r, pwr_r;
	logic [1:0]         pmode_r;
	logic [SLOTS-1:0]   sdb_bits_r;
	logic               sdb_intr_r;
	logic               fifo_in_ready;

	////////////////////////////////////////////////////////////////////////
	// lowest set issue bit picks the next slot
	function automatic logic [SLOT_W-1:0] low_slot(input logic [SLOTS-1:0] v);
		logic [SLOT_W-1:0] r;
		r = '0;
		for (int i = SLOTS-1; i >= 0; i--)
			if (v[i])
				r = SLOT_W'(i);
		return r;
	endfunction

	// only these five kinds are decoded; legacy queued frames never match
	wire frm_reg  = i_frm_valid && (i_frm_kind == FRM_REG);
	wire frm_pios = i_frm_valid && (i_frm_kind == FRM_PIOS);
	wire frm_data = i_frm_valid && (i_frm_kind == FRM_DATA);
	wire frm_dmas = i_frm_valid && (i_frm_kind == FRM_DMAS);
	wire frm_sdb  = i_frm_valid && (i_frm_kind == FRM_SDB);
	wire [SLOTS-1:0] slot_bit = BIT_ONE << slot_r;
	// a quiet completion of a queued command only drops the issue bit
	wire clr_ci  = (st_r == ST_D2H_QUIET) || (st_r == ST_D2H_INT);
	wire clr_sact = (st_r == ST_SDB);
	wire [SLOTS-1:0] ci_after   = ci_r & ~(clr_ci ? slot_bit : BITS_ZERO);
	wire [SLOTS-1:0] sact_after = sact_r & ~(clr_sact ? sdb_bits_r
		: BITS_ZERO);
	wire [SLOTS-1:0] ci_nxt   = ci_after | i_issue_set;
	wire [SLOTS-1:0] sact_nxt = sact_after | i_active_set;
	wire last_done = (ci_after == BITS_ZERO) && (sact_after == BITS_ZERO);

	////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
		ST_IDLE:
			if (frm_pios)
				st_nxt = ST_PIO_ENT;
			else if (frm_data)
				st_nxt = ST_PIO_RX;
			else if (frm_dmas)
				st_nxt = ST_DMA_SET;
			else if (frm_sdb)
				st_nxt = ST_SDB;
			else if (frm_reg)
				st_nxt = (i_frm_intr && !q_r) ? ST_D2H_INT
					: ST_D2H_QUIET;
			else if (ci_r != BITS_ZERO && !i_rx_busy)
				st_nxt = ST_FETCH;
		ST_FETCH:
			if (i_step_done)
				st_nxt = ST_XMIT;
		ST_XMIT:
			if (i_tx_ok)
				st_nxt = !pf_r ? ST_IDLE
					: (pkt_r ? ST_PF_PKT : ST_PF_DESC);
		ST_PF_PKT:
			if (i_step_done)
				st_nxt = ST_PF_DESC;
		ST_PF_DESC:
			if (i_step_done)
				st_nxt = ST_IDLE;
		ST_PIO_ENT:
			st_nxt = (pkt_r && !pkt_sent_r) ? ST_PKT_ENT : ST_IDLE;
		ST_PKT_ENT:
			if (i_step_done)
				st_nxt = ST_PIO_UPD;
		ST_PIO_UPD:
			st_nxt = ST_IDLE;
		ST_PIO_RX:
			if (i_step_done)
				st_nxt = ST_IDLE;
		ST_D2H_INT, ST_D2H_QUIET, ST_SDB:
			st_nxt = ST_PWR;
		ST_DMA_SET:
			st_nxt = ST_IDLE;
		ST_PWR:
			st_nxt = ST_IDLE;
		default:
			st_nxt = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// state and slot bookkeeping; header bits latched at fetch
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_r       <= ST_IDLE;
			ci_r       <= '0;
			sact_r     <= '0;
			slot_r     <= '0;
			pkt_r      <= 1'b0;
			pf_r       <= 1'b0;
			q_r        <= 1'b0;
			pkt_sent_r <= 1'b0;
		end
		else
		begin
			st_r   <= st_nxt;
			ci_r   <= ci_nxt;
			sact_r <= sact_nxt;
			if (st_r == ST_IDLE && st_nxt == ST_FETCH)
			begin
				slot_r     <= low_slot(ci_r);
				pkt_r      <= i_hdr_packet;
				pf_r       <= i_hdr_prefetch;
				q_r        <= i_hdr_queued;
				pkt_sent_r <= 1'b0;
			end
			else if (st_r == ST_PIO_UPD)
				pkt_sent_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// set-device-bits payload held from the accepting edge: the link shows
	// it only during the frame pulse, one cycle before the bits are cleared
	wire sdb_take = (st_r == ST_IDLE) && frm_sdb;
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sdb_bits_r <= '0;
			sdb_intr_r <= 1'b0;
		end
		else if (sdb_take)
		begin
			sdb_bits_r <= i_frm_sdb_bits;
			sdb_intr_r <= i_frm_intr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt pulse and power request, both registered
	wire want_int = (st_r == ST_D2H_INT)
		|| (clr_sact && sdb_intr_r);
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			intr_r  <= 1'b0;
			pwr_r   <= 1'b0;
			pmode_r <= PWR_PARTIAL;
		end
		else
		begin
			intr_r  <= want_int;
			// nothing issued and nothing active: the last command is done
			pwr_r   <= (st_r == ST_PWR) && i_aggr_pm_en && last_done;
			pmode_r <= i_slumber_sel ? PWR_SLUMBER : PWR_PARTIAL;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive data path; the link stalls when the buffer fills
	wire rx_go = (st_r == ST_PIO_RX);
	assign o_rx_ready = rx_go && fifo_in_ready;

	pqf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.i_clk       (i_clk),
		.i_nrst      (i_nrst),
		.i_in_valid  (i_rx_valid && rx_go),
		.i_in_data   (i_rx_data),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (o_mem_valid),
		.o_out_data  (o_mem_data),
		.i_out_ready (i_mem_ready)
	);

	assign o_command_issue_bits = ci_r;
	assign o_queued_active_bits = sact_r;
	assign o_slot               = slot_r;
	assign o_state              = st_r;
	assign o_intr               = intr_r;
	assign o_pwr_req            = pwr_r;
	assign o_pwr_mode           = pmode_r;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	pf_desc_idle_a: assert property ((st_r == ST_PF_DESC && i_step_done)
		|=> st_r == ST_IDLE) else $error("prefetch did not idle");
	pf_pkt_order_a: assert property ((st_r == ST_XMIT && i_tx_ok && pf_r
		&& pkt_r) |=> st_r == ST_PF_PKT) else $error("no packet prefetch");
	pio_entry_a: assert property ((st_r == ST_IDLE && frm_pios)
		|=> st_r == ST_PIO_ENT) else $error("pio setup missed");
	pio_rx_a: assert property ((st_r == ST_IDLE && frm_data)
		|=> st_r == ST_PIO_RX) else $error("data frame missed");
	pkt_path_a: assert property ((st_r == ST_PIO_ENT && pkt_r && !pkt_sent_r)
		|=> st_r == ST_PKT_ENT) else $error("packet entry skipped");
	d2h_intr_a: assert property ((st_r == ST_D2H_INT) |=> o_intr)
		else $error("no interrupt on register frame");
	pwr_req_a: assert property ((st_r == ST_PWR && i_aggr_pm_en
		&& ci_r == BITS_ZERO && sact_r == BITS_ZERO) |=> o_pwr_req)
		else $error("power request missing");
	ci_clear_a: assert property ((st_r == ST_D2H_QUIET && i_issue_set == '0
		&& i_active_set == '0) |=> (!ci_r[$past(slot_r)]
		&& sact_r == $past(sact_r))) else $error("issue bit kept");
	sdb_clear_a: assert property ((st_r == ST_IDLE && frm_sdb)
		##1 (i_active_set == '0) |=> (sact_r & $past(i_frm_sdb_bits, 2)) == '0)
		else $error("active bits kept");
	fetch_next_a: assert property ((st_r == ST_IDLE && ci_r != '0
		&& !i_rx_busy && !i_frm_valid) |=> st_r == ST_FETCH)
		else $error("issued command not fetched");
	idle_hold_a: assert property ((st_r == ST_IDLE && ci_r == '0
		&& !i_frm_valid) |=> st_r == ST_IDLE)
		else $error("left idle without work");
	sdb_intr_a: assert property ((st_r == ST_IDLE && frm_sdb && i_frm_intr)
		|=> ##1 o_intr)
		else $error("no interrupt on set-device-bits");
	pf_desc_first_a: assert property ((st_r == ST_XMIT && i_tx_ok && pf_r
		&& !pkt_r) |=> st_r == ST_PF_DESC)
		else $error("descriptor prefetch skipped");
	pkt_upd_a: assert property ((st_r == ST_PKT_ENT && i_step_done)
		|=> st_r == ST_PIO_UPD)
		else $error("pio update skipped");
	sdb_entry_a: assert property ((st_r == ST_IDLE && frm_sdb)
		|=> st_r == ST_SDB)
		else $error("set-device-bits missed");
	quiet_path_a: assert property ((st_r == ST_IDLE && frm_reg
		&& (!i_frm_intr || q_r)) |=> st_r == ST_D2H_QUIET)
		else $error("quiet completion missed");

	pkt_read_c: cover property (st_r == ST_PKT_ENT ##[1:20] st_r == ST_PIO_RX);
	queued_c: cover property (st_r == ST_D2H_QUIET ##[1:50] st_r == ST_SDB);
	pwr_c: cover property (o_pwr_req);
	sdb_intr_c: cover property (st_r == ST_SDB ##1 o_intr);
	fifo_full_c: cover property (rx_go && !fifo_in_ready);
endmodule

// [pqf_drv.sv]
// pqf_drv: behavioural drive model on the link side of the sequencer
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/100ps
module pqf_drv
	import pqf_pkg::*;
(
	// clock and flow control
	input  wire logic         i_clk,
	input  wire logic         i_rx_ready,
	// frames and transmit result
	output logic              o_frm_valid,
	output logic [2:0]        o_frm_kind,
	output logic              o_frm_intr,
	output logic [SLOTS-1:0]  o_frm_sdb_bits,
	output logic              o_tx_ok,
	// received data stream
	output logic              o_rx_valid,
	output logic [DATA_W-1:0] o_rx_data
);
	// idle link at time zero
	initial
	begin
		o_frm_valid = 1'b0;
		o_frm_kind = 3'h0;
		o_frm_intr = 1'b0;
		o_frm_sdb_bits = 32'h0000_0000;
		o_tx_ok = 1'b0;
		o_rx_valid = 1'b0;
		o_rx_data = 32'h0000_0000;
	end
	////////////////////////////////////////////////////////////////////////
	// frame pulse driven at once: a late frame would let a refetch slip in
	task automatic frame(input logic [2:0] k, input logic intr,
		input logic [SLOTS-1:0] bits);
		o_frm_valid = 1'b1;
		o_frm_kind = k;
		o_frm_intr = intr;
		o_frm_sdb_bits = bits;
		@(negedge i_clk);
		o_frm_valid = 1'b0;
		o_frm_kind = ~k;
		o_frm_intr = ~intr;
		o_frm_sdb_bits = ~bits;
	endtask
	// successful command frame transmission, one cycle
	task automatic tx();
		o_tx_ok = 1'b1;
		@(negedge i_clk);
		o_tx_ok = 1'b0;
	endtask
	// each word held until a rising edge sees ready; gap models a slow drive
	task automatic stream(input int n, input int gap,
		input logic [DATA_W-1:0] base);
		for (int i = 0; i < n; i++)
		begin
			o_rx_valid = 1'b1;
			o_rx_data = base + DATA_W'(i);
			while (i_rx_ready !== 1'b1)
				@(negedge i_clk);
			@(negedge i_clk);
			o_rx_valid = 1'b0;
			o_rx_data = ~o_rx_data;
			repeat (gap) @(negedge i_clk);
		end
	endtask
endmodule

// [pqf_seq_tb.sv]
// pqf_seq_tb: self-checking bench for the port command sequencer
// assumes pqf_drv stands in for the drive; inputs change at falling edges
`timescale 1ns/100ps
module pqf_seq_tb
	import pqf_pkg::*;
;
	logic i_clk = 1'b0, i_nrst = 1'b0, i_step_done = 1'b0, i_mem_ready = 1'b0;
	logic i_hdr_prefetch = 1'b0, i_hdr_packet = 1'b0, i_hdr_queued = 1'b0;
	logic i_aggr_pm_en = 1'b1, i_slumber_sel = 1'b0, i_rx_busy = 1'b0;
	logic [SLOTS-1:0] i_issue_set = '0, i_active_set = '0, o_issue, o_active;
	logic frm_valid, frm_intr, tx_ok, rx_valid, o_rx_ready, o_mem_valid;
	logic o_intr, o_pwr_req;
	logic [2:0] frm_kind;
	logic [1:0] o_pwr_mode, pwr_mode_seen;
	logic [SLOTS-1:0] sdb_bits;
	logic [DATA_W-1:0] rx_data, o_mem_data;
	logic [SLOT_W-1:0] o_slot;
	logic [3:0] o_state;
	int errors = 0, samples_checked = 0, cyc = 0, intr_n = 0, pwr_n = 0;
	////////////////////////////////////////////////////////////////////////
	// 250 MHz clock; cycle ceiling far above the roughly 130 cycles the tests use
	always #2 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (o_intr === 1'b1) intr_n <= intr_n + 1;
		if (o_pwr_req === 1'b1) pwr_n <= pwr_n + 1;
		if (o_pwr_req === 1'b1) pwr_mode_seen <= o_pwr_mode;
		if (cyc == 5000)
		begin
			errors++;
			wrap_up();
		end
	end
	pqf_seq i_pqf_seq (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_issue_set(i_issue_set), .i_active_set(i_active_set),
		.i_hdr_prefetch(i_hdr_prefetch), .i_hdr_packet(i_hdr_packet),
		.i_hdr_queued(i_hdr_queued), .i_aggr_pm_en(i_aggr_pm_en),
		.i_slumber_sel(i_slumber_sel), .i_step_done(i_step_done),
		.i_tx_ok(tx_ok), .i_rx_busy(i_rx_busy), .i_frm_valid(frm_valid),
		.i_frm_kind(frm_kind), .i_frm_intr(frm_intr),
		.i_frm_sdb_bits(sdb_bits), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .o_rx_ready(o_rx_ready),
		.o_mem_valid(o_mem_valid), .o_mem_data(o_mem_data),
		.i_mem_ready(i_mem_ready), .o_command_issue_bits(o_issue),
		.o_queued_active_bits(o_active), .o_slot(o_slot),
		.o_state(o_state), .o_intr(o_intr), .o_pwr_req(o_pwr_req),
		.o_pwr_mode(o_pwr_mode));
	pqf_drv i_pqf_drv (.i_clk(i_clk), .i_rx_ready(o_rx_ready),
		.o_frm_valid(frm_valid), .o_frm_kind(frm_kind),
		.o_frm_intr(frm_intr), .o_frm_sdb_bits(sdb_bits), .o_tx_ok(tx_ok),
		.o_rx_valid(rx_valid), .o_rx_data(rx_data));
	////////////////////////////////////////////////////////////////////////
	// shared compare, state poll and pulse helpers
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic st(input logic [3:0] s, input int n);
		for (int i = 0; i < n && o_state !== s; i++)
			@(negedge i_clk);
		chk("state", {28'h0000000, s}, {28'h0000000, o_state});
	endtask
	task automatic step();
		i_step_done = 1'b1;
		@(negedge i_clk);
		i_step_done = 1'b0;
	endtask
	// fetch and send one command; busy link keeps it from refetching
	task automatic send(input logic [SLOT_W-1:0] slot);
		st(ST_FETCH, 20);
		chk("slot", {27'h0, slot}, {27'h0, o_slot});
		step();
		st(ST_XMIT, 20);
		i_rx_busy = 1'b1;
		i_pqf_drv.tx();
	endtask
	////////////////////////////////////////////////////////////////////////
	// plain pio read, prefetch set: straight to descriptor fetch
	task automatic t_plain();
		i_hdr_prefetch = 1'b1;
		i_issue_set = 32'h0000_0002;
		@(negedge i_clk);
		i_issue_set = '0;
		send(5'h01);
		st(ST_PF_DESC, 0);
		step();
		st(ST_IDLE, 20);
		i_pqf_drv.frame(FRM_PIOS, 1'b0, '0);
		st(ST_PIO_ENT, 0);
		@(negedge i_clk);
		st(ST_IDLE, 0);
		i_pqf_drv.frame(FRM_REG, 1'b0, '0);
		st(ST_D2H_QUIET, 20);
		st(ST_IDLE, 20);
		@(negedge i_clk);
		chk("issue", 32'h0, o_issue);
		chk("pwr", 32'd1, pwr_n);
		chk("pwr mode", {30'h0, PWR_PARTIAL}, {30'h0, pwr_mode_seen});
		i_rx_busy = 1'b0;
	endtask
	// packet pio read with fifo filled to refusal, then drained in order
	task automatic t_packet();
		i_hdr_packet = 1'b1;
		i_slumber_sel = 1'b1;
		i_issue_set = 32'h0000_0008;
		@(negedge i_clk);
		i_issue_set = '0;
		send(5'h03);
		st(ST_PF_PKT, 0);
		step();
		st(ST_PF_DESC, 0);
		// one idle edge so the strobe is not driven twice at one instant
		@(negedge i_clk);
		step();
		st(ST_IDLE, 20);
		i_pqf_drv.frame(FRM_PIOS, 1'b0, '0);
		st(ST_PIO_ENT, 0);
		st(ST_PKT_ENT, 20);
		step();
		st(ST_PIO_UPD, 20);
		st(ST_IDLE, 20);
		i_pqf_drv.frame(FRM_PIOS, 1'b0, '0);
		st(ST_IDLE, 20);
		i_pqf_drv.frame(FRM_DATA, 1'b0, '0);
		fork
			i_pqf_drv.stream(10, 1, 32'ha5a5_0000);
			begin
				st(ST_PIO_RX, 0);
				repeat (30) @(negedge i_clk);
				chk("rx ready full", 32'h0, {31'h0, o_rx_ready});
				i_mem_ready = 1'b1;
				for (int k = 0; k < 10; )
				begin
					if (o_mem_valid === 1'b1)
					begin
						chk("mem data", 32'ha5a5_0000 + k, o_mem_data);
						k++;
					end
					@(negedge i_clk);
				end
				i_mem_ready = 1'b0;
				chk("mem empty", 32'h0, {31'h0, o_mem_valid});
			end
		join
		step();
		st(ST_IDLE, 20);
		i_pqf_drv.frame(FRM_REG, 1'b1, '0);
		st(ST_D2H_INT, 0);
		repeat (6) @(negedge i_clk);
		chk("intr", 32'd1, intr_n);
		chk("pwr", 32'd2, pwr_n);
		chk("pwr mode", {30'h0, PWR_SLUMBER}, {30'h0, pwr_mode_seen});
		i_rx_busy = 1'b0;
		i_hdr_prefetch = 1'b0;
		i_hdr_packet = 1'b0;
	endtask
	// four queued commands, then set-device-bits completions
	task automatic t_queued();
		logic [SLOT_W-1:0] sl [4] = '{5'h00, 5'h02, 5'h05, 5'h08};
		logic [31:0] left [4] = '{32'h124, 32'h120, 32'h100, 32'h0};
		i_hdr_queued = 1'b1;
		i_slumber_sel = 1'b0;
		i_active_set = 32'h0000_0125;
		i_issue_set = 32'h0000_0125;
		@(negedge i_clk);
		i_active_set = '0;
		i_issue_set = '0;
		for (int j = 0; j < 4; j++)
		begin
			send(sl[j]);
			st(ST_IDLE, 0);
			i_pqf_drv.frame(FRM_REG, 1'b0, '0);
			st(ST_D2H_QUIET, 20);
			st(ST_IDLE, 20);
			repeat (2) @(negedge i_clk);
			st(ST_IDLE, 0);
			chk("issue", left[j], o_issue);
			chk("active", 32'h125, o_active);
			i_rx_busy = 1'b0;
		end
		i_pqf_drv.frame(FRM_DMAS, 1'b0, '0);
		st(ST_DMA_SET, 0);
		st(ST_IDLE, 20);
		i_pqf_drv.frame(FRM_SDB, 1'b1, 32'h0000_0024);
		st(ST_SDB, 0);
		repeat (6) @(negedge i_clk);
		chk("active", 32'h101, o_active);
		chk("intr", 32'd2, intr_n);
		chk("pwr", 32'd2, pwr_n);
		i_pqf_drv.frame(FRM_SDB, 1'b1, 32'h0000_0101);
		repeat (6) @(negedge i_clk);
		chk("active", 32'h0, o_active);
		chk("intr", 32'd3, intr_n);
		chk("pwr", 32'd3, pwr_n);
	endtask
	////////////////////////////////////////////////////////////////////////
	// closing report and verdict
	task automatic wrap_up();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// reset, idle checks, then the scenarios in turn
	initial
	begin
		repeat (6) @(negedge i_clk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_clk);
		st(ST_IDLE, 0);
		chk("issue", 32'h0, o_issue);
		chk("mode", 32'h1, {30'h0, o_pwr_mode});
		t_plain();
		t_packet();
		t_queued();
		wrap_up();
	end
endmodule
